// ==== pkg/ugr_pkg.sv ====
package ugr_pkg;

  // Glyph RAM geometry: sixteen patterns of eight rows, one byte each.
  localparam int GLYPHS = 16;
  localparam int PAT_ROWS = 8;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CODE_W = 8;
  localparam int ROW_W = 3;
  localparam int DOT_W = 5;

  // Field positions inside the glyph RAM address and the character code.
  localparam int ADDR_ROW_LSB = 0;
  localparam int ADDR_CODE_LSB = 3;
  localparam int ADDR_HI_BIT = 6;
  localparam int SET_ADDR_W = 6;
  localparam int CODE_LO_LSB = 0;
  localparam int CODE_HI_LSB = 4;
  localparam int NIB_W = 4;

  // The last pattern row doubles as the cursor line.
  localparam logic [2:0] CURSOR_ROW = 3'h7;

  // Values after reset.
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [4:0] DOTS_RST = 5'h00;
  localparam logic [31:0] ROW_DRV_RST = 32'h0000_0000;

  // Text RAM placement of the second panel row.
  localparam logic [6:0] HALF_LINE_OFS = 7'h0C;
  localparam logic [6:0] LINE2_BASE = 7'h40;

  // Row drivers: thirty-two outputs, partners sixteen apart in 1:16.
  localparam int ROW_OUTS = 32;
  localparam int PAIR_OFS = 16;

endpackage : ugr_pkg

// ==== verilog/ugr_mem.sv ====
`timescale 1ns/1ps
module ugr_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Synchronous reset of the read registers.
  input wire logic ce_i, // Clock enable.
  input wire logic we_i, // Write strobe.
  input wire logic [AW-1:0] waddr_i, // Write address.
  input wire logic [DW-1:0] wdata_i, // Write data.
  input wire logic [AW-1:0] ra_addr_i, // Read port A address.
  output logic [DW-1:0] ra_data_o, // Read port A data, registered.
  input wire logic [AW-1:0] rb_addr_i, // Read port B address.
  output logic [DW-1:0] rb_data_o // Read port B data, registered.
);

  generate
    if (AW < 1 || DW < 1) begin : g_chk
      $error("ugr_mem needs positive widths.");
    end
  endgenerate

  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // Contents carry no reset; software loads every pattern it uses.
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  // A read in the cycle of a write to the same word returns the old word.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ra_data_o <= '0;
      rb_data_o <= '0;
    end else if (ce_i) begin
      ra_data_o <= mem_q[ra_addr_i];
      rb_data_o <= mem_q[rb_addr_i];
    end
  end

endmodule : ugr_mem

// ==== verilog/ugr_top.sv ====
`timescale 1ns/1ps
module ugr_top #(
  parameter int GLYPHS = ugr_pkg::GLYPHS,
  parameter int PAT_ROWS = ugr_pkg::PAT_ROWS
) (
  input wire logic CLK_I, // Controller clock.
  input wire logic RST_I, // Synchronous reset, active high.
  input wire logic CE_I, // Clock enable, freezes all state when low.
  input wire logic SET_UGR_ADDR_I, // Set glyph address, one-cycle pulse.
  input wire logic SET_TEXT_ADDR_I, // Set text address, one-cycle pulse.
  input wire logic WR_DATA_I, // Write data, one-cycle pulse.
  input wire logic RD_DATA_I, // Read data, one-cycle pulse.
  input wire logic [7:0] HOST_DATA_I, // Host data or address operand.
  input wire logic INC_I, // Entry mode: 1 increment, 0 decrement.
  output logic [7:0] RD_DATA_O, // Glyph RAM read data.
  output logic RD_VALID_O, // Read data valid, one-cycle pulse.
  output logic [6:0] ADDR_O, // Address counter for the status read.
  output logic UGR_SEL_O, // Address counter points at glyph RAM.
  input wire logic DISP_REQ_I, // Display fetch request, one-cycle pulse.
  input wire logic [7:0] DISP_CODE_I, // Character code to render.
  input wire logic [2:0] DISP_ROW_I, // Dot row within the character.
  input wire logic CURSOR_I, // Cursor line active for this cell.
  input wire logic [4:0] ROM_DOTS_I, // Fixed glyph ROM dots, bit 4 left.
  output logic [4:0] DOTS_O, // Column dots, bit 4 leftmost, 1 = on.
  output logic DOTS_VALID_O, // Dots valid, one-cycle pulse.
  output logic USER_GLYPH_O, // Dots came from the glyph RAM.
  input wire logic MODE_M_I, // Function setup multiplex bit.
  input wire logic MODE_N_I, // Function setup line-count bit.
  input wire logic POS_ROW_I, // Panel row of the cell, 0 or 1.
  input wire logic [4:0] POS_COL_I, // Panel column of the cell.
  output logic [6:0] TEXT_ADDR_O, // Text RAM address of the cell.
  input wire logic [4:0] ROW_IDX_I, // Active multiplex row index.
  output logic [31:0] ROW_DRV_O, // Row driver select, one bit per output.
  output logic PAIRED_O // Row outputs are driven in pairs.
);

  generate
    if (GLYPHS * PAT_ROWS != (1 << ugr_pkg::ADDR_W)) begin : g_chk
      $error("ugr_top needs GLYPHS * PAT_ROWS equal to the address space.");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [6:0] step_addr(input logic [6:0] a,
                                           input logic up);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    return r;
  endfunction : step_addr

  function automatic logic single_line(input logic m, input logic n);
    logic r;
    r = !m && !n;
    return r;
  endfunction : single_line

  ////////////////////////////////////////////////////////////////////////
  // Address counter and host access.

  logic [6:0] ac_q;
  logic [6:0] ac_d;
  logic sel_q;
  logic sel_d;
  logic rd_pend_q;
  logic rd_pend_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic mem_we;
  logic [7:0] host_rdata;

  // A new address load outranks a data access in the same cycle.
  always_comb begin
    ac_d = ac_q;
    sel_d = sel_q;
    mem_we = 1'b0;
    rd_pend_d = 1'b0;
    if (SET_TEXT_ADDR_I) begin
      ac_d = HOST_DATA_I[6:0];
      sel_d = 1'b0;
    end else if (SET_UGR_ADDR_I) begin
      ac_d = {ac_q[ugr_pkg::ADDR_HI_BIT],
              HOST_DATA_I[ugr_pkg::SET_ADDR_W-1:0]};
      sel_d = 1'b1;
    end else if (WR_DATA_I && sel_q) begin
      mem_we = 1'b1;
      ac_d = step_addr(ac_q, INC_I);
    end else if (RD_DATA_I && sel_q) begin
      rd_pend_d = 1'b1;
      ac_d = step_addr(ac_q, INC_I);
    end
  end

  // Read data keeps all eight bits, the undisplayed top three included.
  always_comb begin
    rd_data_d = rd_data_q;
    rd_valid_d = rd_pend_q;
    if (rd_pend_q) begin
      rd_data_d = host_rdata;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ac_q <= ugr_pkg::ADDR_RST;
      sel_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_data_q <= ugr_pkg::DATA_RST;
      rd_valid_q <= 1'b0;
    end else if (CE_I) begin
      ac_q <= ac_d;
      sel_q <= sel_d;
      rd_pend_q <= rd_pend_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Glyph RAM.

  logic [6:0] disp_addr;
  logic [7:0] disp_rdata;

  assign disp_addr = {DISP_CODE_I[ugr_pkg::CODE_LO_LSB +: ugr_pkg::NIB_W],
                      DISP_ROW_I};

  // Sixteen patterns of eight rows fill the 128-word store.
  ugr_mem #(
    .AW(ugr_pkg::ADDR_W),
    .DW(ugr_pkg::DATA_W)
  ) u_mem (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .we_i(mem_we),
    .waddr_i(ac_q),
    .wdata_i(HOST_DATA_I),
    .ra_addr_i(ac_q),
    .ra_data_o(host_rdata),
    .rb_addr_i(disp_addr),
    .rb_data_o(disp_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Display lookup, two cycles from request to dots.

  logic s1_valid_q;
  logic s1_valid_d;
  logic s1_user_q;
  logic s1_user_d;
  logic s1_curs_q;
  logic s1_curs_d;
  logic [4:0] s1_rom_q;
  logic [4:0] s1_rom_d;

  always_comb begin
    s1_valid_d = DISP_REQ_I;
    s1_user_d = s1_user_q;
    s1_curs_d = s1_curs_q;
    s1_rom_d = s1_rom_q;
    if (DISP_REQ_I) begin
      s1_user_d = DISP_CODE_I[ugr_pkg::CODE_HI_LSB +: ugr_pkg::NIB_W]
                  == 4'h0;
      s1_curs_d = CURSOR_I && (DISP_ROW_I == ugr_pkg::CURSOR_ROW);
      s1_rom_d = ROM_DOTS_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s1_valid_q <= 1'b0;
      s1_user_q <= 1'b0;
      s1_curs_q <= 1'b0;
      s1_rom_q <= ugr_pkg::DOTS_RST;
    end else if (CE_I) begin
      s1_valid_q <= s1_valid_d;
      s1_user_q <= s1_user_d;
      s1_curs_q <= s1_curs_d;
      s1_rom_q <= s1_rom_d;
    end
  end

  logic [4:0] dots_q;
  logic [4:0] dots_d;
  logic dots_valid_q;
  logic dots_valid_d;
  logic user_q;
  logic user_d;
  logic [4:0] pat;

  // Only the low five data bits reach the columns; bit 4 is leftmost.
  always_comb begin
    pat = s1_user_q ? disp_rdata[ugr_pkg::DOT_W-1:0]
                    : s1_rom_q;
    dots_d = dots_q;
    user_d = user_q;
    dots_valid_d = s1_valid_q;
    if (s1_valid_q) begin
      dots_d = pat | {ugr_pkg::DOT_W{s1_curs_q}};
      user_d = s1_user_q;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      dots_q <= ugr_pkg::DOTS_RST;
      dots_valid_q <= 1'b0;
      user_q <= 1'b0;
    end else if (CE_I) begin
      dots_q <= dots_d;
      dots_valid_q <= dots_valid_d;
      user_q <= user_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Panel layout and row drivers.

  logic [6:0] taddr_q;
  logic [6:0] taddr_d;
  logic [31:0] rdrv_q;
  logic [31:0] rdrv_d;
  logic paired_q;
  logic paired_d;
  logic [3:0] half_idx;

  assign half_idx = ROW_IDX_I[3:0];

  // Single-line mode folds the 24-character line onto two rows of 12.
  always_comb begin
    paired_d = single_line(MODE_M_I, MODE_N_I);
    taddr_d = {2'h0, POS_COL_I};
    if (POS_ROW_I) begin
      if (paired_d) begin
        taddr_d = 7'(taddr_d + ugr_pkg::HALF_LINE_OFS);
      end else begin
        taddr_d = 7'(taddr_d + ugr_pkg::LINE2_BASE);
      end
    end
  end

  // Paired outputs let the panel wire two drivers to one row.
  always_comb begin
    rdrv_d = ugr_pkg::ROW_DRV_RST;
    if (paired_d) begin
      rdrv_d[half_idx] = 1'b1;
      rdrv_d[5'(half_idx) + 5'(ugr_pkg::PAIR_OFS)] = 1'b1;
    end else begin
      rdrv_d[ROW_IDX_I] = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      taddr_q <= ugr_pkg::ADDR_RST;
      rdrv_q <= ugr_pkg::ROW_DRV_RST;
      paired_q <= 1'b0;
    end else if (CE_I) begin
      taddr_q <= taddr_d;
      rdrv_q <= rdrv_d;
      paired_q <= paired_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign RD_DATA_O = rd_data_q;
  assign RD_VALID_O = rd_valid_q;
  assign ADDR_O = ac_q;
  assign UGR_SEL_O = sel_q;
  assign DOTS_O = dots_q;
  assign DOTS_VALID_O = dots_valid_q;
  assign USER_GLYPH_O = user_q;
  assign TEXT_ADDR_O = taddr_q;
  assign ROW_DRV_O = rdrv_q;
  assign PAIRED_O = paired_q;

endmodule : ugr_top

// ==== test/ugr_host.sv ====
`timescale 1ns/1ps
module ugr_host (
  input wire logic clk_i, // Clock.
  output logic set_ugr_o, // Glyph address load.
  output logic set_text_o, // Text address load.
  output logic wr_o, // Data write.
  output logic rd_o, // Data read.
  output logic [7:0] data_o, // Operand.
  output logic m_o, // Multiplex bit.
  output logic n_o // Line-count bit.
);
  initial begin
    {set_text_o, set_ugr_o, wr_o, rd_o, m_o, n_o} = 6'h00;
    data_o = 8'h00;
  end
  // Kind 0 loads text, 1 glyph, 2 writes, 3 reads; the operand is
  // inverted on release so the block cannot lean on a stale value.
  task automatic op(input int k, input logic [7:0] d);
    @(negedge clk_i);
    data_o = d;
    {set_text_o, set_ugr_o, wr_o, rd_o} = 4'h8 >> k;
    @(negedge clk_i);
    {set_text_o, set_ugr_o, wr_o, rd_o} = 4'h0;
    data_o = ~d;
  endtask : op
  // Both bits zero select single-line mode, folded onto two rows at 1:16.
  task automatic mode(input logic m, input logic n);
    {m_o, n_o} = {m, n};
  endtask : mode
endmodule : ugr_host

// ==== test/ugr_top_sva.sv ====
`timescale 1ns/1ps
module ugr_top_sva (
  input logic CLK_I, // Clock.
  input logic RST_I, // Reset.
  input logic CE_I, // Clock enable.
  input logic SET_UGR_ADDR_I, // Glyph load.
  input logic SET_TEXT_ADDR_I, // Text load.
  input logic WR_DATA_I, // Write.
  input logic RD_DATA_I, // Read.
  input logic [7:0] HOST_DATA_I, // Operand.
  input logic INC_I, // Step up.
  input logic RD_VALID_O, // Read valid.
  input logic [6:0] ADDR_O, // Counter.
  input logic UGR_SEL_O, // Glyph target.
  input logic DISP_REQ_I, // Fetch.
  input logic [7:0] DISP_CODE_I, // Code.
  input logic [2:0] DISP_ROW_I, // Dot row.
  input logic CURSOR_I, // Cursor.
  input logic [4:0] ROM_DOTS_I, // ROM dots.
  input logic [4:0] DOTS_O, // Dots.
  input logic DOTS_VALID_O, // Dots valid.
  input logic USER_GLYPH_O, // From RAM.
  input logic MODE_M_I, // Mux bit.
  input logic MODE_N_I, // Lines bit.
  input logic POS_ROW_I, // Cell row.
  input logic [4:0] POS_COL_I, // Cell column.
  input logic [6:0] TEXT_ADDR_O, // Text address.
  input logic [31:0] ROW_DRV_O, // Rows.
  input logic PAIRED_O // Paired.
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // An access only counts while enabled and when no load outranks it.
  sequence s_acc;
    CE_I && UGR_SEL_O && !SET_TEXT_ADDR_I && !SET_UGR_ADDR_I;
  endsequence
  sequence s_rd;
    s_acc ##0 RD_DATA_I && !WR_DATA_I;
  endsequence
  a_rd_answer: assert property (s_rd |-> ##2 RD_VALID_O)
    else $error("read answer missing");
  a_wr_step: assert property (s_acc ##0 WR_DATA_I |=> ADDR_O ==
    $past(ADDR_O) + ($past(INC_I) ? 7'h01 : 7'h7F)) else $error("bad step");
  a_glyph_load: assert property (SET_UGR_ADDR_I && !SET_TEXT_ADDR_I
    |=> UGR_SEL_O && ADDR_O == {$past(ADDR_O[6]), $past(HOST_DATA_I[5:0])})
    else $error("glyph load wrong");
  a_text_load: assert property (SET_TEXT_ADDR_I |=> !UGR_SEL_O &&
    ADDR_O == $past(HOST_DATA_I[6:0])) else $error("text load wrong");
  a_ram_pick: assert property (DISP_REQ_I |-> ##2 DOTS_VALID_O &&
    USER_GLYPH_O == ($past(DISP_CODE_I[7:4], 2) == 4'h0))
    else $error("source pick wrong");
  a_cursor_or: assert property (DISP_REQ_I && CURSOR_I &&
    DISP_ROW_I == 3'h7 |-> ##2 DOTS_O == 5'h1F) else $error("no cursor");
  a_rom_dots: assert property (DISP_REQ_I && !CURSOR_I &&
    DISP_CODE_I[7:4] != 4'h0 |-> ##2 DOTS_O == $past(ROM_DOTS_I, 2))
    else $error("rom dots wrong");
  a_pair_rows: assert property (PAIRED_O |-> ROW_DRV_O != 32'h0 &&
    ROW_DRV_O[15:0] == ROW_DRV_O[31:16]) else $error("rows not paired");
  a_pair_mode: assert property (!MODE_M_I && !MODE_N_I |=> PAIRED_O)
    else $error("pairing missing");
  a_half_line: assert property (PAIRED_O && $past(POS_ROW_I) |->
    TEXT_ADDR_O == {2'h0, $past(POS_COL_I)} + 7'h0C)
    else $error("second row address wrong");
endmodule : ugr_top_sva
bind ugr_top ugr_top_sva u_sva (.*);

// ==== test/test_ugr_top.sv ====
`timescale 1ns/1ps
module test_ugr_top;
  logic clk, rst, ce, inc, dreq, cur, prow, rdv, usel, dv, ug, pr;
  logic [7:0] code, rdd;
  logic [2:0] row;
  logic [4:0] rom, col, ridx, dots;
  logic [6:0] ad, ta;
  logic [31:0] rdrv;
  logic [7:0] ram [128];
  wire logic su, st, wr, rd, m, n;
  wire logic [7:0] hd;
  int errors, n_tests;
  ugr_host h (.clk_i(clk), .set_ugr_o(su), .set_text_o(st), .wr_o(wr),
    .rd_o(rd), .data_o(hd), .m_o(m), .n_o(n));
  ugr_top uut (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .SET_UGR_ADDR_I(su),
    .SET_TEXT_ADDR_I(st), .WR_DATA_I(wr), .RD_DATA_I(rd), .HOST_DATA_I(hd),
    .INC_I(inc), .RD_DATA_O(rdd), .RD_VALID_O(rdv), .ADDR_O(ad),
    .UGR_SEL_O(usel), .DISP_REQ_I(dreq), .DISP_CODE_I(code),
    .DISP_ROW_I(row), .CURSOR_I(cur), .ROM_DOTS_I(rom), .DOTS_O(dots),
    .DOTS_VALID_O(dv), .USER_GLYPH_O(ug), .MODE_M_I(m), .MODE_N_I(n),
    .POS_ROW_I(prow), .POS_COL_I(col), .TEXT_ADDR_O(ta),
    .ROW_IDX_I(ridx), .ROW_DRV_O(rdrv), .PAIRED_O(pr));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic wait_v(input logic dsp);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if ((dsp ? dv : rdv) === 1'b1) return;
    end
    errors++;
    complete_run();
  endtask : wait_v
  function automatic logic [4:0] exp_dots(input logic [7:0] c,
      input logic [2:0] r, input logic cu, input logic [4:0] ro);
    logic [4:0] b;
    b = (c[7:4] == 4'h0) ? ram[{c[3:0], r}][4:0] : ro;
    return b | {5{cu && r == 3'h7}};
  endfunction : exp_dots
  function automatic logic [31:0] exp_row(input logic p, input logic [4:0] x);
    if (p) return (32'h1 << x[3:0]) | (32'h1 << (x[3:0] + 5'h10));
    return 32'h1 << x;
  endfunction : exp_row
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, inc, dreq, cur, prow, code, row, rom, col, ridx} = 31'h6000_0000;
    ce = 1'b1;
    errors = 0;
    n_tests = 0;
    void'($urandom(49));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    chk({usel, ad}, 8'h00);
    h.op(1, 8'h3F);
    chk({usel, ad}, 8'hBF);
    h.op(2, 8'hA5);
    chk(ad, 7'h40);
    h.op(1, 8'h05);
    chk(ad, 7'h45);
    h.op(0, 8'h47);
    h.op(2, 8'h11);
    h.op(3, 8'h00);
    // A refused read must neither step the counter nor answer.
    @(negedge clk);
    chk(rdv, 1'b0);
    chk({usel, ad}, 8'h47);
    h.op(1, 8'h01);
    chk({usel, ad}, 8'hC1);
    // With the clock enable low a write strobe must leave the counter.
    ce = 1'b0;
    h.op(2, 8'h5A);
    chk({usel, ad}, 8'hC1);
    ce = 1'b1;
    $display("test address load done");
    h.op(0, 8'h00);
    h.op(1, 8'h00);
    for (int i = 0; i < 128; i++) begin
      ram[i] = 8'($urandom);
      h.op(2, ram[i]);
    end
    chk(ad, 7'h00);
    inc = 1'b0;
    h.op(2, ram[0]);
    chk(ad, 7'h7F);
    inc = 1'b1;
    h.op(0, 8'h00);
    h.op(1, 8'h00);
    for (int i = 0; i < 128; i++) begin
      h.op(3, 8'h00);
      wait_v(1'b0);
      chk(rdd, ram[i]);
    end
    $display("test glyph ram done");
    for (int i = 0; i < 160; i++) begin
      @(negedge clk);
      {code, row, cur, rom} = 17'($urandom);
      if (i[0]) code[7:4] = 4'h0;
      if (i < 2) {code, row, cur} = {8'h0F + 8'(i), 4'hF};
      dreq = 1'b1;
      @(negedge clk);
      dreq = 1'b0;
      wait_v(1'b1);
      chk(dots, exp_dots(code, row, cur, rom));
      chk(ug, code[7:4] == 4'h0);
    end
    $display("test display fetch done");
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      h.mode(i[1], i[2]);
      {prow, ridx} = 6'($urandom);
      col = 5'($urandom % 12);
      @(negedge clk);
      chk(ta, {2'h0, col} + (prow ? ((m | n) ? 7'h40 : 7'h0C)
        : 7'h00));
      chk(pr, !(m | n));
      chk(rdrv, exp_row(!(m | n), ridx));
    end
    $display("test panel layout done");
    complete_run();
  end
endmodule : test_ugr_top
